// *** include/gpio_pkg.sv ***
// Register indices, field layout and reset values for the GPIO block
package gpio_pkg;
  // ==========================================================
  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_P4_ANALOG = 8'haf;
  localparam logic [7:0] IDX_ADC_MODE = 8'hb1;
  localparam logic [7:0] IDX_P0_DIR = 8'hb8;
  localparam logic [7:0] IDX_P4_DIR = 8'hc4;
  localparam logic [7:0] IDX_P5_DIR = 8'hc5;
  localparam logic [7:0] IDX_P0_DATA = 8'hd0;
  localparam logic [7:0] IDX_P4_DATA = 8'hd4;
  localparam logic [7:0] IDX_P5_DATA = 8'hd5;
  localparam logic [7:0] IDX_P0_PU = 8'he0;
  localparam logic [7:0] IDX_P4_PU = 8'he4;
  localparam logic [7:0] IDX_P5_PU = 8'he5;
  localparam logic [7:0] IDX_BIT_OP = 8'hf0;
  // ==========================================================
  // Implemented and fixed bits
  localparam logic [7:0] P0_IMPL = 8'hf7;
  localparam logic [7:0] P0_DATA_WR = 8'h6f;
  localparam logic [7:0] P45_IMPL = 8'h1f;
  localparam logic [7:0] ADM_IMPL = 8'hf7;
  localparam logic [7:0] P0_PIN3_ONE = 8'h08;
  localparam logic [7:0] NO_ONES = 8'h00;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] P0_FIXED_RST = 8'h08;
  localparam int P0_PIN3 = 3;
  // ==========================================================
  // Converter mode fields
  localparam int ADM_ANALOG_GLOBAL_CHANNEL_ENABLE = 4;
  localparam int ADM_CHS_MSB = 2;
  localparam logic [2:0] AIN_PIN_COUNT = 3'd5;
  // ==========================================================
  // Bit set/clear command fields
  localparam int BOP_IDX_MSB = 7;
  localparam int BOP_BIT_LSB = 8;
  localparam int BOP_BIT_MSB = 10;
  localparam int BOP_VAL = 11;
  // ==========================================================
  // Bus constants
  localparam logic [2:0] HSIZE_WORD = 3'b010;
  localparam int HTRANS_ACTIVE = 1;
endpackage

// *** design/port_pin_stage.sv ***
// Output stage of one port: drive, pull-up and sampled pin levels
`timescale 1ns/1ps
module port_pin_stage #(
  parameter int W = 8
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [W-1:0] dir, // 1 = output
  input wire logic [W-1:0] latch, // Output latch
  input wire logic [W-1:0] pu, // Pull-up enables
  input wire logic [W-1:0] isolate, // Digital paths cut
  input wire logic [W-1:0] in_only, // Pins that never drive
  input wire logic [W-1:0] pin_in, // Pin levels
  output logic [W-1:0] pad_out, // Drive value
  output logic [W-1:0] pad_oe, // Drive enable
  output logic [W-1:0] pad_pu, // Pull-up on
  output logic [W-1:0] pin_level // Sampled digital level
);
  // ==========================================================
  // Drive path: latch always follows even when not driven, so a
  // direction change never shows a stale value
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_out <= '0;
      pad_oe <= '0;
    end else begin
      pad_out <= latch;
      pad_oe <= dir & ~isolate & ~in_only;
    end
  end

  // Pull-ups are cut on isolated and input-only pins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pad_pu <= '0;
    end else begin
      pad_pu <= pu & ~isolate & ~in_only;
    end
  end

  // Isolated pins read low to avoid a floating analog level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_level <= '0;
    end else begin
      pin_level <= pin_in & ~isolate;
    end
  end
endmodule

// *** design/gpio_ports.sv ***
// GPIO ports 0, 4 and 5 with converter pin sharing, AHB-Lite slave
// Functional notes
// - Direction bit: 0 input, 1 output
// - Port0 pin3 input only, direction reads 1
// - All-ones pull-up writes enable every pull-up
// - Port0 pin3 no pull-up, bit holds 1
// - External reset option forces pin3 read 1
// - Data read returns present pin levels
// - Data write loads the output latch
// - At most one port4 pin is analog input
// - Analog-only bit isolates the pin's digital paths
// - Global enable 0 routes no pin
// - Global enable 1 claims selected pin
// - Channel select 000 to 101 picks channel
`timescale 1ns/1ps
module gpio_ports
  import gpio_pkg::*;
(
  input wire logic clk, // System clock, 125 MHz
  input wire logic rstn, // Async reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // 1 = write
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic ext_reset_sel, // External reset option strap
  input wire logic [7:0] p0_pin_in, // Port0 pin levels
  output logic [7:0] p0_pin_out, // Port0 drive value
  output logic [7:0] p0_pin_oe, // Port0 drive enable
  output logic [7:0] p0_pullup, // Port0 pull-up on
  input wire logic [4:0] p4_pin_in, // Port4 pin levels
  output logic [4:0] p4_pin_out, // Port4 drive value
  output logic [4:0] p4_pin_oe, // Port4 drive enable
  output logic [4:0] p4_pullup, // Port4 pull-up on
  input wire logic [4:0] p5_pin_in, // Port5 pin levels
  output logic [4:0] p5_pin_out, // Port5 drive value
  output logic [4:0] p5_pin_oe, // Port5 drive enable
  output logic [4:0] p5_pullup, // Port5 pull-up on
  output logic [4:0] adc_pin_sel, // Port4 pin routed to converter
  output logic adc_route_en // Converter channel enabled
);
  // ==========================================================
  // Register state
  logic [7:0] port4_analog_only_cfg;
  logic [7:0] adc_mode_ctrl;
  logic [7:0] port0_direction;
  logic [7:0] port4_direction;
  logic [7:0] port5_direction;
  logic [7:0] port0_data;
  logic [7:0] port4_data;
  logic [7:0] port5_data;
  logic [7:0] port0_pullup_enable;
  logic [7:0] port4_pullup_enable;
  logic [7:0] port5_pullup_enable;
  logic ext_sel_q;
  logic wr_pend;
  logic [7:0] wr_idx;
  logic rd_pend;
  logic [7:0] rd_idx;
  logic addr_ok;
  logic addr_mapped;
  logic [7:0] addr_idx;
  logic [7:0] rd_val;
  logic [4:0] ain_onehot;
  logic [4:0] p4_isolate;
  logic [7:0] p0_level;
  logic [4:0] p4_level;
  logic [4:0] p5_level;
  logic [2:0] analog_channel_select;
  logic analog_global_channel_enable;

  // ==========================================================
  // Register update: word write or single-bit set/clear
  function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] idx,
                                     input logic [7:0] keep, input logic [7:0] ones,
                                     input logic w_now, input logic [7:0] w_idx,
                                     input logic [31:0] wd);
    logic [7:0] v;
    v = cur;
    if (w_now && w_idx == idx) begin
      v = wd[7:0];
    end else if (w_now && w_idx == IDX_BIT_OP && wd[BOP_IDX_MSB:0] == idx) begin
      v[wd[BOP_BIT_MSB:BOP_BIT_LSB]] = wd[BOP_VAL];
    end
    return (v & keep) | ones;
  endfunction

  // ==========================================================
  // Bus address phase
  assign addr_ok = hsel && htrans[HTRANS_ACTIVE] && hready;
  assign addr_mapped = (haddr[31:10] == 22'h0);
  assign addr_idx = addr_mapped ? haddr[9:2] : 8'h00;

  // Capture address phase; sub-word writes are dropped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      rd_pend <= 1'b0;
      rd_idx <= 8'h00;
    end else begin
      wr_pend <= addr_ok && hwrite && (hsize == HSIZE_WORD);
      rd_pend <= addr_ok && !hwrite;
      if (addr_ok) begin
        wr_idx <= addr_idx;
        rd_idx <= addr_idx;
      end
    end
  end

  // One wait state on reads so a write just before is seen
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hreadyout <= 1'b1;
    end else begin
      hreadyout <= !(addr_ok && !hwrite);
    end
  end

  // Response is always OKAY
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // ==========================================================
  // Strap for the external reset option, resampled on every clock after release
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ext_sel_q <= 1'b0;
    end else begin
      ext_sel_q <= ext_reset_sel;
    end
  end

  // ==========================================================
  // Direction registers; port0 pin3 stays 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port0_direction <= P0_FIXED_RST;
      port4_direction <= REG_RST;
      port5_direction <= REG_RST;
    end else begin
      port0_direction <= upd(port0_direction, IDX_P0_DIR, P0_IMPL, P0_PIN3_ONE,
                             wr_pend, wr_idx, hwdata);
      port4_direction <= upd(port4_direction, IDX_P4_DIR, P45_IMPL, NO_ONES,
                             wr_pend, wr_idx, hwdata);
      port5_direction <= upd(port5_direction, IDX_P5_DIR, P45_IMPL, NO_ONES,
                             wr_pend, wr_idx, hwdata);
    end
  end

  // Output latches; port0 bits 7 and 4 are read-only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port0_data <= REG_RST;
      port4_data <= REG_RST;
      port5_data <= REG_RST;
    end else begin
      port0_data <= upd(port0_data, IDX_P0_DATA, P0_DATA_WR, NO_ONES,
                        wr_pend, wr_idx, hwdata);
      port4_data <= upd(port4_data, IDX_P4_DATA, P45_IMPL, NO_ONES,
                        wr_pend, wr_idx, hwdata);
      port5_data <= upd(port5_data, IDX_P5_DATA, P45_IMPL, NO_ONES,
                        wr_pend, wr_idx, hwdata);
    end
  end

  // Pull-up enables; port0 pin3 control bit pinned to 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port0_pullup_enable <= P0_FIXED_RST;
      port4_pullup_enable <= REG_RST;
      port5_pullup_enable <= REG_RST;
    end else begin
      port0_pullup_enable <= upd(port0_pullup_enable, IDX_P0_PU, P0_IMPL, P0_PIN3_ONE,
                                 wr_pend, wr_idx, hwdata);
      port4_pullup_enable <= upd(port4_pullup_enable, IDX_P4_PU, P45_IMPL, NO_ONES,
                                 wr_pend, wr_idx, hwdata);
      port5_pullup_enable <= upd(port5_pullup_enable, IDX_P5_PU, P45_IMPL, NO_ONES,
                                 wr_pend, wr_idx, hwdata);
    end
  end

  // Analog sharing controls
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port4_analog_only_cfg <= REG_RST;
      adc_mode_ctrl <= REG_RST;
    end else begin
      port4_analog_only_cfg <= upd(port4_analog_only_cfg, IDX_P4_ANALOG, P45_IMPL,
                                   NO_ONES, wr_pend, wr_idx, hwdata);
      adc_mode_ctrl <= upd(adc_mode_ctrl, IDX_ADC_MODE, ADM_IMPL, NO_ONES,
                           wr_pend, wr_idx, hwdata);
    end
  end

  // ==========================================================
  // Channel routing: channel 5 has no port4 pin, so it claims none
  assign analog_channel_select = adc_mode_ctrl[ADM_CHS_MSB:0];
  assign analog_global_channel_enable = adc_mode_ctrl[ADM_ANALOG_GLOBAL_CHANNEL_ENABLE];
  always_comb begin
    ain_onehot = 5'h00;
    if (analog_global_channel_enable && analog_channel_select < AIN_PIN_COUNT) begin
      ain_onehot = 5'(5'h01 << analog_channel_select);
    end
  end
  assign p4_isolate = port4_analog_only_cfg[4:0] | ain_onehot;

  // Converter routing outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      adc_pin_sel <= 5'h00;
      adc_route_en <= 1'b0;
    end else begin
      adc_pin_sel <= ain_onehot;
      adc_route_en <= analog_global_channel_enable;
    end
  end

  // ==========================================================
  // Pin stages
  port_pin_stage #(.W(8)) u_port0 (
    .clk(clk),
    .rstn(rstn),
    .dir(port0_direction),
    .latch(port0_data),
    .pu(port0_pullup_enable),
    .isolate(8'h00),
    .in_only(P0_PIN3_ONE),
    .pin_in(p0_pin_in),
    .pad_out(p0_pin_out),
    .pad_oe(p0_pin_oe),
    .pad_pu(p0_pullup),
    .pin_level(p0_level)
  );

  port_pin_stage #(.W(5)) u_port4 (
    .clk(clk),
    .rstn(rstn),
    .dir(port4_direction[4:0]),
    .latch(port4_data[4:0]),
    .pu(port4_pullup_enable[4:0]),
    .isolate(p4_isolate),
    .in_only(5'h00),
    .pin_in(p4_pin_in),
    .pad_out(p4_pin_out),
    .pad_oe(p4_pin_oe),
    .pad_pu(p4_pullup),
    .pin_level(p4_level)
  );

  port_pin_stage #(.W(5)) u_port5 (
    .clk(clk),
    .rstn(rstn),
    .dir(port5_direction[4:0]),
    .latch(port5_data[4:0]),
    .pu(port5_pullup_enable[4:0]),
    .isolate(5'h00),
    .in_only(5'h00),
    .pin_in(p5_pin_in),
    .pad_out(p5_pin_out),
    .pad_oe(p5_pin_oe),
    .pad_pu(p5_pullup),
    .pin_level(p5_level)
  );

  // ==========================================================
  // Read mux: data registers show pins, not latches
  always_comb begin
    rd_val = 8'h00;
    unique case (rd_idx)
      IDX_P4_ANALOG: rd_val = port4_analog_only_cfg;
      IDX_ADC_MODE: rd_val = adc_mode_ctrl;
      IDX_P0_DIR: rd_val = port0_direction;
      IDX_P4_DIR: rd_val = port4_direction;
      IDX_P5_DIR: rd_val = port5_direction;
      IDX_P0_DATA: rd_val = p0_level | (ext_sel_q ? P0_PIN3_ONE : NO_ONES);
      IDX_P4_DATA: rd_val = {3'b000, p4_level};
      IDX_P5_DATA: rd_val = {3'b000, p5_level};
      IDX_P0_PU: rd_val = port0_pullup_enable;
      IDX_P4_PU: rd_val = port4_pullup_enable;
      IDX_P5_PU: rd_val = port5_pullup_enable;
      default: rd_val = 8'h00;
    endcase
  end

  // Read data loads during the wait state and then holds
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h0;
    end else if (rd_pend && !hreadyout) begin
      hrdata <= {24'h0, rd_val};
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence wr_p5_data_s;
    addr_ok && hwrite && hsize == HSIZE_WORD && addr_mapped && addr_idx == IDX_P5_DATA;
  endsequence
  sequence wr_p5_pu_ones_s;
    addr_ok && hwrite && hsize == HSIZE_WORD && addr_mapped && addr_idx == IDX_P5_PU
      ##1 hwdata[7:0] == 8'hff;
  endsequence
  sequence rd_p_s(logic [7:0] idx);
    rd_pend && !hreadyout && rd_idx == idx;
  endsequence

  input_only_a: assert property (port0_direction[P0_PIN3] && !p0_pin_oe[P0_PIN3])
    else $error("port0 pin3 direction or drive wrong");
  dir_drive_a: assert property (1'b1 |=> p5_pin_oe == $past(port5_direction[4:0]))
    else $error("port5 drive does not follow direction");
  pullup_ones_a: assert property (wr_p5_pu_ones_s |=> ##1 p5_pullup == 5'h1f)
    else $error("pull-ups not all on after all-ones write");
  pullup_pin3_a: assert property (port0_pullup_enable[P0_PIN3] && !p0_pullup[P0_PIN3])
    else $error("port0 pin3 pull-up state wrong");
  ext_read_a: assert property (rd_p_s(IDX_P0_DATA) and ext_sel_q |=> hrdata[P0_PIN3])
    else $error("port0 pin3 not read as 1 under reset option");
  pin_read_a: assert property (rd_p_s(IDX_P5_DATA) |=> hrdata[4:0] == $past(p5_level))
    else $error("port5 read does not return pin levels");
  latch_load_a: assert property (wr_p5_data_s ##1 1'b1 |=> port5_data[4:0] ==
    $past(hwdata[4:0]))
    else $error("port5 latch not loaded by write");
  single_ain_a: assert property ($onehot0(adc_pin_sel))
    else $error("more than one converter pin selected");
  isolate_a: assert property (1'b1 |=> (p4_pin_oe & $past(port4_analog_only_cfg[4:0])) == 5'h00
    && (p4_pullup & $past(port4_analog_only_cfg[4:0])) == 5'h00)
    else $error("isolated port4 pin still driven");
  route_off_a: assert property (!analog_global_channel_enable |=> adc_pin_sel == 5'h00 && !adc_route_en)
    else $error("converter pin routed while disabled");
  route_sel_a: assert property (analog_global_channel_enable && analog_channel_select < AIN_PIN_COUNT |=> adc_pin_sel ==
    5'(5'h01 << $past(analog_channel_select)) && !(|(p4_pin_oe & adc_pin_sel)))
    else $error("selected channel pin not claimed");
  bit_op_a: assert property (wr_pend && wr_idx == IDX_BIT_OP && hwdata[7:0] == IDX_P5_DIR
    |=> ((port5_direction ^ $past(port5_direction)) &
    ~(8'(8'h01 << $past(hwdata[BOP_BIT_MSB:BOP_BIT_LSB])))) == 8'h00)
    else $error("bit operation disturbed other bits");
endmodule

// *** dv/pin_partner.sv ***
// Behavioural model of the pads and the outside world on one port
`timescale 1ns/1ps
module pin_partner #(
  parameter int W = 5
) (
  input wire logic clk, // System clock
  input wire logic [W-1:0] out, // Drive value from the port
  input wire logic [W-1:0] oe, // Drive enable from the port
  input wire logic [W-1:0] pu, // Pull-up request from the port
  input wire logic [W-1:0] ext_val, // Level of the outside source
  input wire logic [W-1:0] ext_on, // Outside source connected
  output logic [W-1:0] pin // Resolved pin level
);
  // ==========================================================
  // Wire resolution
  logic [W-1:0] wander = '0;
  // Pattern for a pin nobody holds, so a stale level never passes
  always @(posedge clk) begin
    wander <= ~wander;
  end
  // Port driver wins over the outside source, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) begin
        pin[i] = out[i];
      end else if (ext_on[i]) begin
        pin[i] = ext_val[i];
      end else if (pu[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = wander[i];
      end
    end
  end
endmodule

// *** dv/gpio_ports_with_adc_pin_share_tb_top.sv ***
// Self-checking bench for the GPIO ports with converter pin sharing
`timescale 1ns/1ps
module gpio_ports_with_adc_pin_share_tb_top;
  import gpio_pkg::*;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic ext_reset_sel = 1'b0;
  logic hreadyout, hresp;
  logic [31:0] hrdata;
  logic [7:0] p0_in, p0_out, p0_oe, p0_pu, p0_ext = 8'h5a;
  logic [4:0] p4_in, p4_out, p4_oe, p4_pu, p4_ext = 5'h15;
  logic [4:0] p5_in, p5_out, p5_oe, p5_pu, p5_ext = 5'h0a;
  logic [4:0] adc_pin_sel, sel;
  logic [7:0] p0_on = 8'hff;
  logic [4:0] p4_on = 5'h1f;
  logic [4:0] p5_on = 5'h1f;
  logic adc_route_en;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;
  logic [7:0] ridx [11] = '{IDX_P4_ANALOG, IDX_ADC_MODE, IDX_P0_DIR, IDX_P4_DIR, IDX_P5_DIR,
    IDX_P0_PU, IDX_P4_PU, IDX_P5_PU, IDX_P0_DATA, IDX_P4_DATA, IDX_P5_DATA};
  logic [7:0] rexp [11] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00, 8'h5a,
    8'h15, 8'h0a};
  // ==========================================================
  // Design and pads
  gpio_ports u_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .ext_reset_sel(ext_reset_sel),
    .p0_pin_in(p0_in), .p0_pin_out(p0_out), .p0_pin_oe(p0_oe), .p0_pullup(p0_pu),
    .p4_pin_in(p4_in), .p4_pin_out(p4_out), .p4_pin_oe(p4_oe), .p4_pullup(p4_pu),
    .p5_pin_in(p5_in), .p5_pin_out(p5_out), .p5_pin_oe(p5_oe), .p5_pullup(p5_pu),
    .adc_pin_sel(adc_pin_sel), .adc_route_en(adc_route_en));
  pin_partner #(.W(8)) u_p0 (.clk(clk), .out(p0_out), .oe(p0_oe), .pu(p0_pu),
    .ext_val(p0_ext), .ext_on(p0_on), .pin(p0_in));
  pin_partner #(.W(5)) u_p4 (.clk(clk), .out(p4_out), .oe(p4_oe), .pu(p4_pu),
    .ext_val(p4_ext), .ext_on(p4_on), .pin(p4_in));
  pin_partner #(.W(5)) u_p5 (.clk(clk), .out(p5_out), .oe(p5_oe), .pu(p5_pu),
    .ext_val(p5_ext), .ext_on(p5_on), .pin(p5_in));
  // ==========================================================
  // Clock and hang guard
  initial begin
    forever #4 clk = ~clk;
  end
  // Whole run needs a few hundred cycles; this ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Tasks
  task automatic report_and_stop();
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single word transfer; the wait lengths come from hready alone
  task automatic bus(input logic [7:0] idx, input logic wr_n, input logic [31:0] wd,
                     output logic [31:0] rd_v);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr_n;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_v = hrdata;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] unused;
    bus(idx, 1'b1, d, unused);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] got;
    bus(idx, 1'b0, 32'h0, got);
    chk(got, exp);
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Pads follow a register one edge after it loads
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ==========================================================
  // Test sequence
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 11; i++) begin
      rd(ridx[i], {24'h0, rexp[i]});
    end
    // Latch first, then turn the port round to drive
    wr(IDX_P0_DATA, 32'hff);
    wr(IDX_P0_DIR, 32'hff);
    settle();
    chk(p0_oe, 8'hf7);
    chk(p0_out & p0_oe, 8'h67);
    rd(IDX_P0_DATA, 32'h6f);
    wr(IDX_P0_DIR, 32'h00);
    rd(IDX_P0_DIR, 32'h08);
    // Reset strap overrides the low pin only while selected
    @(posedge clk);
    ext_reset_sel <= 1'b1;
    p0_ext <= 8'h00;
    rd(IDX_P0_DATA, 32'h08);
    @(posedge clk);
    ext_reset_sel <= 1'b0;
    rd(IDX_P0_DATA, 32'h00);
    // Pull-ups, all ones on every port
    wr(IDX_P0_PU, 32'hff);
    wr(IDX_P4_PU, 32'hff);
    wr(IDX_P5_PU, 32'hff);
    settle();
    chk(p0_pu, 8'hf7);
    chk(p4_pu, 5'h1f);
    chk(p5_pu, 5'h1f);
    // Outside source let go: pull-ups alone hold port5 high
    @(posedge clk);
    p5_on <= 5'h00;
    rd(IDX_P5_DATA, 32'h1f);
    p5_on <= 5'h1f;
    wr(IDX_P0_PU, 32'h00);
    rd(IDX_P0_PU, 32'h08);
    // Port5 drive, then single-bit updates
    wr(IDX_P5_DATA, 32'h15);
    wr(IDX_P5_DIR, 32'h1f);
    settle();
    chk(p5_oe, 5'h1f);
    chk(p5_out, 5'h15);
    wr(IDX_BIT_OP, {20'h0, 1'b1, 3'd1, IDX_P5_DATA});
    wr(IDX_BIT_OP, {20'h0, 1'b0, 3'd4, IDX_P5_DATA});
    wr(IDX_BIT_OP, {20'h0, 1'b0, 3'd0, IDX_P5_DIR});
    settle();
    chk(p5_out, 5'h07);
    rd(IDX_P5_DIR, 32'h1e);
    rd(IDX_P5_DATA, 32'h06);
    // Converter claims one port4 pin for channel codes 0 to 4, none for code 5
    wr(IDX_P4_DATA, 32'h1f);
    wr(IDX_P4_DIR, 32'h1f);
    for (int c = 0; c < 6; c++) begin
      sel = (c < 5) ? 5'(1 << c) : 5'h00;
      wr(IDX_ADC_MODE, 32'h10 | 32'(c));
      settle();
      chk(adc_pin_sel, sel);
      chk(adc_route_en, 1'b1);
      chk(p4_oe, 5'h1f & ~sel);
    end
    wr(IDX_ADC_MODE, 32'h01);
    settle();
    chk(adc_pin_sel, 5'h00);
    chk(adc_route_en, 1'b0);
    chk(p4_oe, 5'h1f);
    chk(p4_out, 5'h1f);
    rd(IDX_ADC_MODE, 32'h01);
    // Analog-only pin loses its digital paths
    wr(IDX_P4_ANALOG, 32'h04);
    settle();
    chk(p4_oe, 5'h1b);
    chk(p4_pu, 5'h1b);
    rd(IDX_P4_DATA, 32'h1b);
    rd(IDX_P4_ANALOG, 32'h04);
    // Unmapped word: write dropped, read empty
    wr(8'h10, 32'hff);
    rd(8'h10, 32'h00);
    report_and_stop();
  end
endmodule
